// ===== src/press_pkg.sv
// Constants, register map and state encodings of the pressure sensor core.
// Assumes a 100 MHz core clock; every user reaches names as press_pkg::name.
package press_pkg;
    localparam int CLK_MHZ = 100;
    localparam int MS_CYCLES = CLK_MHZ * 1000;
    localparam logic [6:0] DEV_ADDR = 7'h5D;
    localparam logic [7:0] IDX_POWER = 8'h12;
    localparam logic [7:0] IDX_RELEASE = 8'h13;
    localparam logic [7:0] IDX_MODE = 8'h14;
    localparam logic [7:0] IDX_STATUS = 8'h19;
    localparam logic [7:0] IDX_P_HIGH = 8'h1A;
    localparam logic [7:0] IDX_P_MID = 8'h1B;
    localparam logic [7:0] IDX_P_FRAC = 8'h1C;
    localparam logic [7:0] IDX_T_HIGH = 8'h1D;
    localparam logic [7:0] IDX_T_LOW = 8'h1E;
    localparam logic [7:0] MODE_RST = 8'h08;
    localparam int AVG_HI = 7;
    localparam int AVG_LO = 5;
    localparam int PIN_EN_BIT = 4;
    localparam logic [2:0] AVG_INHIBIT = 3'h7;
    localparam logic [1:0] MODE_STANDBY = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_REPEAT = 2'h2;
    localparam logic [1:0] MODE_PROHIBIT = 2'h3;
    localparam int P_W = 22;
    localparam int T_W = 16;
    localparam int ACC_EXTRA = 6;
    // Longest conversion time and repeat period in ms, indexed by averaging code.
    localparam int unsigned TM_MS [7] = '{6, 9, 16, 30, 60, 120, 240};
    localparam int unsigned TI_MS [7] = '{60, 60, 60, 60, 60, 120, 240};
    typedef enum logic [2:0] {
        CV_IDLE = 3'h1, CV_CONV = 3'h2, CV_WAIT = 3'h4
    } conv_state_e;
    typedef enum logic [6:0] {
        BS_IDLE = 7'h01, BS_ADDR = 7'h02, BS_AACK = 7'h04, BS_WR = 7'h08,
        BS_WACK = 7'h10, BS_RD = 7'h20, BS_RACK = 7'h40
    } bus_state_e;
endpackage : press_pkg

// ===== src/sample_if.sv
// Carries one pressure and temperature sample from the front-end domain to the core.
// Assumes a toggle handshake: data holds still until the ack toggle matches the request.
interface sample_if;
    logic req_tgl;
    logic ack_tgl;
    logic [21:0] pressure;
    logic [15:0] temp;
    modport src (output req_tgl, output pressure, output temp, input ack_tgl);
    modport dst (input req_tgl, input pressure, input temp, output ack_tgl);
endinterface : sample_if

// ===== src/sample_bridge.sv
// Front-end side of the sample crossing, clocked by the analogue front end.
// Assumes the front end pulses valid with a stable sample; samples offered while busy drop.
module sample_bridge (
    input wire logic i_afe_clk,
    input wire logic i_rst_b,
    input wire logic i_sample_valid,
    input wire logic [21:0] i_pressure_sample,
    input wire logic [15:0] i_temp_sample,
    sample_if.src link
);
    logic rst_s1_q, rst_s2_q, ack_s1_q, ack_s2_q, req_q;
    logic [21:0] p_q;
    logic [15:0] t_q;
    wire idle = (ack_s2_q == req_q);

    always_ff @(posedge i_afe_clk) begin
        rst_s1_q <= i_rst_b;
        rst_s2_q <= rst_s1_q;
        ack_s1_q <= link.ack_tgl;
        ack_s2_q <= ack_s1_q;
    end

    always_ff @(posedge i_afe_clk) begin
        if (!rst_s2_q) begin
            req_q <= 1'h0;
            p_q <= 22'h0;
            t_q <= 16'h0;
        end else if (i_sample_valid && idle) begin
            req_q <= ~req_q;
            p_q <= i_pressure_sample;
            t_q <= i_temp_sample;
        end
    end

    assign link.req_tgl = req_q;
    assign link.pressure = p_q;
    assign link.temp = t_q;
endmodule : sample_bridge

// ===== src/press_sensor.sv
// Pressure sensor core: two-wire target, registers and measurement sequencer.
// Assumes open-drain pads resolved outside; samples arrive in the front-end clock domain.

module press_sensor #(
    parameter int unsigned P_MS_CYCLES = press_pkg::MS_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_afe_clk,
    input wire logic i_sample_valid,
    input wire logic [21:0] i_pressure_sample,
    input wire logic [15:0] i_temp_sample,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    output logic o_ready_o,
    output logic o_ready_oe
);
    sample_if link ();

    sample_bridge u_bridge (
        .i_afe_clk(i_afe_clk),
        .i_rst_b(i_rst_b),
        .i_sample_valid(i_sample_valid),
        .i_pressure_sample(i_pressure_sample),
        .i_temp_sample(i_temp_sample),
        .link(link.src)
    );

    // Sample arrival from the front-end domain.
    logic req_s1_q, req_s2_q, req_s3_q;
    logic [21:0] smp_p_q;
    logic [15:0] smp_t_q;
    logic smp_new_q;

    always_ff @(posedge i_core_clk) begin
        req_s1_q <= link.req_tgl;
        req_s2_q <= req_s1_q;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            req_s3_q <= 1'h0;
            smp_new_q <= 1'h0;
            smp_p_q <= 22'h0;
            smp_t_q <= 16'h0;
        end else begin
            req_s3_q <= req_s2_q;
            smp_new_q <= req_s2_q ^ req_s3_q;
            if (req_s2_q ^ req_s3_q) begin
                smp_p_q <= link.pressure;
                smp_t_q <= link.temp;
            end
        end
    end
    assign link.ack_tgl = req_s3_q;

    // Two-wire pins, synchronised before use.
    logic scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
    always_ff @(posedge i_core_clk) begin
        scl_s1_q <= i_scl;
        scl_s2_q <= scl_s1_q;
        scl_s3_q <= scl_s2_q;
        sda_s1_q <= i_sda;
        sda_s2_q <= sda_s1_q;
        sda_s3_q <= sda_s2_q;
    end
    wire scl_rise = scl_s2_q && !scl_s3_q;
    wire scl_fall = !scl_s2_q && scl_s3_q;
    wire bus_start = scl_s2_q && scl_s3_q && !sda_s2_q && sda_s3_q;
    wire bus_stop = scl_s2_q && scl_s3_q && sda_s2_q && !sda_s3_q;

    // Register state.
    logic power_q, release_q, flag_q;
    logic [7:0] mode_q, index_q;
    logic [21:0] res_p_q;
    logic [15:0] res_t_q;
    wire live = power_q && release_q;

    function automatic logic gated(input logic [7:0] idx);
        gated = (idx >= press_pkg::IDX_MODE) && (idx <= press_pkg::IDX_T_LOW);
    endfunction

    function automatic logic [7:0] reg_byte(input logic [7:0] idx);
        case (idx)
            press_pkg::IDX_POWER: reg_byte = {7'h0, power_q};
            press_pkg::IDX_RELEASE: reg_byte = {7'h0, release_q};
            press_pkg::IDX_MODE: reg_byte = mode_q;
            press_pkg::IDX_STATUS: reg_byte = {7'h0, flag_q};
            press_pkg::IDX_P_HIGH: reg_byte = res_p_q[21:14];
            press_pkg::IDX_P_MID: reg_byte = res_p_q[13:6];
            press_pkg::IDX_P_FRAC: reg_byte = {res_p_q[5:0], 2'h0};
            press_pkg::IDX_T_HIGH: reg_byte = res_t_q[15:8];
            press_pkg::IDX_T_LOW: reg_byte = res_t_q[7:0];
            default: reg_byte = 8'h00;
        endcase
    endfunction

    // A gated index reads zero while the measurement side is off.
    wire [7:0] rd_byte = (gated(index_q) && !live) ? 8'h00 : reg_byte(index_q);

    // Two-wire target state machine.
    press_pkg::bus_state_e bs_q;
    logic [7:0] sh_q, tx_q;
    logic [2:0] bit_q;
    logic byte_q, rw_q, match_q, first_q, wr_q, rd_stat_q, sda_oe_q;
    wire [7:0] sh_in = {sh_q[6:0], sda_s2_q};

    always_ff @(posedge i_core_clk) begin
        wr_q <= 1'h0;
        rd_stat_q <= 1'h0;
        if (!i_rst_b || bus_stop) begin
            bs_q <= press_pkg::BS_IDLE;
            sda_oe_q <= 1'h0;
            byte_q <= 1'h0;
            if (!i_rst_b) begin
                index_q <= 8'h00;
                sh_q <= 8'h00;
                tx_q <= 8'h00;
                bit_q <= 3'h0;
                rw_q <= 1'h0;
                match_q <= 1'h0;
                first_q <= 1'h0;
            end
        end else if (bus_start) begin
            bs_q <= press_pkg::BS_ADDR;
            sda_oe_q <= 1'h0;
            bit_q <= 3'h0;
            byte_q <= 1'h0;
        end else begin
            case (bs_q)
                press_pkg::BS_ADDR, press_pkg::BS_WR: begin
                    if (scl_rise) begin
                        sh_q <= sh_in;
                        bit_q <= bit_q + 3'h1;
                        byte_q <= (bit_q == 3'h7);
                        if (bit_q == 3'h7 && bs_q == press_pkg::BS_ADDR) begin
                            match_q <= (sh_in[7:1] == press_pkg::DEV_ADDR);
                            rw_q <= sh_in[0];
                        end
                        if (bit_q == 3'h7 && bs_q == press_pkg::BS_WR) begin
                            if (first_q) begin
                                index_q <= sh_in;
                            end else begin
                                wr_q <= 1'h1;
                            end
                        end
                    end else if (scl_fall && byte_q) begin
                        byte_q <= 1'h0;
                        if (bs_q == press_pkg::BS_WR || match_q) begin
                            sda_oe_q <= 1'h1;
                            bs_q <= (bs_q == press_pkg::BS_WR) ? press_pkg::BS_WACK
                                                               : press_pkg::BS_AACK;
                        end else begin
                            bs_q <= press_pkg::BS_IDLE;
                        end
                    end
                end
                press_pkg::BS_AACK, press_pkg::BS_RACK: begin
                    if (scl_rise && bs_q == press_pkg::BS_RACK && sda_s2_q) begin
                        bs_q <= press_pkg::BS_IDLE;
                    end else if (scl_fall) begin
                        if (rw_q) begin
                            bs_q <= press_pkg::BS_RD;
                            tx_q <= rd_byte;
                            sda_oe_q <= !rd_byte[7];
                            bit_q <= 3'h1;
                            index_q <= index_q + 8'h01;
                            rd_stat_q <= (index_q == press_pkg::IDX_STATUS);
                        end else begin
                            bs_q <= press_pkg::BS_WR;
                            sda_oe_q <= 1'h0;
                            bit_q <= 3'h0;
                            first_q <= 1'h1;
                        end
                    end
                end
                press_pkg::BS_WACK: begin
                    if (scl_fall) begin
                        bs_q <= press_pkg::BS_WR;
                        sda_oe_q <= 1'h0;
                        bit_q <= 3'h0;
                        first_q <= 1'h0;
                        if (!first_q) begin
                            index_q <= index_q + 8'h01;
                        end
                    end
                end
                press_pkg::BS_RD: begin
                    if (scl_fall) begin
                        if (bit_q == 3'h0) begin
                            bs_q <= press_pkg::BS_RACK;
                            sda_oe_q <= 1'h0;
                        end else begin
                            tx_q <= {tx_q[6:0], 1'h0};
                            sda_oe_q <= !tx_q[6];
                            bit_q <= bit_q + 3'h1;
                        end
                    end
                end
                default: bs_q <= press_pkg::BS_IDLE;
            endcase
        end
    end

    // Write decode; a gated write while off is dropped.
    wire wr_pwr = wr_q && (index_q == press_pkg::IDX_POWER);
    wire wr_rel = wr_q && (index_q == press_pkg::IDX_RELEASE);
    wire wr_mode = wr_q && (index_q == press_pkg::IDX_MODE) && live;
    wire [2:0] wr_avg = sh_q[press_pkg::AVG_HI:press_pkg::AVG_LO];
    wire wr_bad = (wr_avg == press_pkg::AVG_INHIBIT)
                  || (sh_q[1:0] == press_pkg::MODE_PROHIBIT);

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            power_q <= 1'h0;
            release_q <= 1'h0;
        end else begin
            if (wr_pwr) begin
                power_q <= sh_q[0];
            end
            if (wr_rel) begin
                release_q <= sh_q[0];
            end
        end
    end

    // Measurement sequencer.
    press_pkg::conv_state_e cs_q;
    logic [31:0] cnt_q;
    logic [6:0] n_q;
    logic [27:0] acc_p_q;
    logic signed [21:0] acc_t_q;
    wire [2:0] avg = mode_q[press_pkg::AVG_HI:press_pkg::AVG_LO];
    wire [2:0] avg_i = (avg == press_pkg::AVG_INHIBIT) ? 3'h0 : avg;
    wire [31:0] tm_cyc = press_pkg::TM_MS[avg_i] * P_MS_CYCLES;
    wire [31:0] ti_cyc = press_pkg::TI_MS[avg_i] * P_MS_CYCLES;
    wire [6:0] n_full = 7'(1 << avg_i);
    wire repeat_md = (mode_q[1:0] == press_pkg::MODE_REPEAT);
    wire full = (n_q == n_full);
    wire done = (cs_q == press_pkg::CV_CONV) && (full || cnt_q >= tm_cyc - 32'h1);
    wire [21:0] avg_p = full ? 22'(acc_p_q >> avg_i) : smp_p_q;
    wire [15:0] avg_t = full ? 16'(acc_t_q >>> avg_i) : smp_t_q;
    wire go = wr_mode && !wr_bad && (sh_q[1:0] != press_pkg::MODE_STANDBY)
              && (cs_q == press_pkg::CV_IDLE) && power_q;
    wire restart = repeat_md && cnt_q >= ti_cyc - 32'h1
                   && (cs_q == press_pkg::CV_WAIT || done);

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b || !release_q) begin
            mode_q <= press_pkg::MODE_RST;
            cs_q <= press_pkg::CV_IDLE;
            res_p_q <= 22'h0;
            res_t_q <= 16'h0;
            cnt_q <= 32'h0;
            n_q <= 7'h0;
            acc_p_q <= 28'h0;
            acc_t_q <= 22'sh0;
        end else if (wr_mode) begin
            mode_q <= wr_bad ? {sh_q[7:2], press_pkg::MODE_STANDBY} : sh_q;
            if (go || restart) begin
                cs_q <= press_pkg::CV_CONV;
            end else if (sh_q[1:0] == press_pkg::MODE_STANDBY || wr_bad) begin
                cs_q <= press_pkg::CV_IDLE;
            end
            cnt_q <= 32'h0;
            n_q <= 7'h0;
            acc_p_q <= 28'h0;
            acc_t_q <= 22'sh0;
        end else begin
            cnt_q <= (cs_q == press_pkg::CV_IDLE || restart) ? 32'h0 : cnt_q + 32'h1;
            if (done) begin
                res_p_q <= avg_p;
                res_t_q <= avg_t;
            end
            if (restart) begin
                cs_q <= press_pkg::CV_CONV;
                n_q <= 7'h0;
                acc_p_q <= 28'h0;
                acc_t_q <= 22'sh0;
            end else if (done) begin
                cs_q <= repeat_md ? press_pkg::CV_WAIT : press_pkg::CV_IDLE;
                if (!repeat_md) begin
                    mode_q[1:0] <= press_pkg::MODE_STANDBY;
                end
            end else if (cs_q == press_pkg::CV_CONV && smp_new_q && !full) begin
                n_q <= n_q + 7'h1;
                acc_p_q <= acc_p_q + 28'(smp_p_q);
                acc_t_q <= acc_t_q + 22'(signed'(smp_t_q));
            end
        end
    end

    // The end of a conversion wins over a status read in the same cycle.
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b || !release_q) begin
            flag_q <= 1'h0;
            o_ready_oe <= 1'h0;
        end else begin
            flag_q <= done || (flag_q && !rd_stat_q && !go);
            o_ready_oe <= (done || (flag_q && !rd_stat_q && !go))
                          && mode_q[press_pkg::PIN_EN_BIT];
        end
    end

    always_ff @(posedge i_core_clk) begin
        o_sda_o <= 1'h0;
        o_ready_o <= 1'h0;
        o_sda_oe <= i_rst_b && sda_oe_q;
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    sequence s_conv_running;
        cs_q == press_pkg::CV_CONV && !done;
    endsequence
    sequence s_standby_write;
        wr_mode && sh_q[1:0] == press_pkg::MODE_STANDBY && !wr_bad;
    endsequence

    property p_refuse_bad;
        wr_mode && wr_bad && release_q |=> cs_q == press_pkg::CV_IDLE
            && mode_q[1:0] == press_pkg::MODE_STANDBY;
    endproperty
    a_refuse_bad: assert property (p_refuse_bad) else $error("refused code started work");
    property p_pin_gate;
        o_ready_oe |-> $past(mode_q[press_pkg::PIN_EN_BIT]);
    endproperty
    a_pin_gate: assert property (p_pin_gate) else $error("ready pin driven while off");
    property p_time_bound;
        cs_q == press_pkg::CV_CONV |-> cnt_q < tm_cyc;
    endproperty
    a_time_bound: assert property (p_time_bound) else $error("conversion overran");
    property p_results_together;
        done && release_q && !wr_mode |=> res_p_q == $past(avg_p) && res_t_q == $past(avg_t);
    endproperty
    a_results_together: assert property (p_results_together) else $error("results split");
    property p_single_ends;
        done && !repeat_md && release_q && !wr_mode |=> mode_q[1:0] == press_pkg::MODE_STANDBY
            && cs_q == press_pkg::CV_IDLE;
    endproperty
    a_single_ends: assert property (p_single_ends) else $error("single did not end");
    property p_abort;
        s_conv_running ##0 s_standby_write |=> cs_q == press_pkg::CV_IDLE && $stable(res_p_q);
    endproperty
    a_abort: assert property (p_abort) else $error("abort changed result");
    property p_flag_set;
        done && release_q |=> flag_q ##1 (flag_q || $past(rd_stat_q) || $past(go));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("data flag missed");
    property p_flag_clear;
        rd_stat_q && !done |=> !flag_q;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("status read kept flag");
    property p_hold_reset;
        !release_q |=> cs_q == press_pkg::CV_IDLE && mode_q == press_pkg::MODE_RST;
    endproperty
    a_hold_reset: assert property (p_hold_reset) else $error("control ran in reset");
    property p_repeat_runs;
        cs_q == press_pkg::CV_WAIT && !wr_mode && release_q |=> cs_q != press_pkg::CV_IDLE;
    endproperty
    a_repeat_runs: assert property (p_repeat_runs) else $error("repeat mode stopped");
endmodule : press_sensor

// ===== test/i2c_host.sv
// Two-wire host model standing in for the processor on the far side.
// Assumes pull-ups for both lines; every step is paced by core clock falls.
module i2c_host (
    input wire logic i_clk,
    input wire logic i_dev_sda_oe,
    output logic o_scl,
    output logic o_sda
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pull_low = 1'b0;
    initial o_scl = 1'b1;
    assign o_sda = !(pull_low || i_dev_sda_oe);
    task automatic step(input int n);
        repeat (n) @(negedge i_clk);
    endtask : step
    // Data moves two cycles after SCL falls, so it is never seen as START or STOP.
    task automatic bit_io(input logic b, output logic r);
        pull_low = !b;
        step(6);
        o_scl = 1'b1;
        step(4);
        r = o_sda;
        step(4);
        o_scl = 1'b0;
        step(2);
    endtask : bit_io
    task automatic start();
        pull_low = 1'b0;
        step(4);
        o_scl = 1'b1;
        step(8);
        pull_low = 1'b1;
        step(8);
        o_scl = 1'b0;
        step(2);
    endtask : start
    task automatic stop();
        pull_low = 1'b1;
        step(4);
        o_scl = 1'b1;
        step(8);
        pull_low = 1'b0;
        step(8);
    endtask : stop
    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask : put
    task automatic get(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask : get
endmodule : i2c_host

// ===== test/tb.sv
// Self-checking bench for the pressure sensor core.
// Assumes the host model and a front end repeating one sample value per test.
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic afe_clk = 1'b0;
    logic rst_b = 1'b0;
    logic sample_valid = 1'b0;
    logic [21:0] p_smp = '0;
    logic [15:0] t_smp = '0;
    logic [21:0] p_old;
    logic [15:0] t_old;
    logic [2:0] afe_cnt = '0;
    logic scl, sda, sda_o, sda_oe, ready_o, ready_oe, ack;
    logic [7:0] rb [6];
    logic [7:0] bad [2] = '{8'hE1, 8'h0B};
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    always #5 core_clk = ~core_clk;
    initial begin
        #3;
        forever #24 afe_clk = ~afe_clk;
    end
    always @(negedge afe_clk) begin
        afe_cnt <= afe_cnt + 3'h1;
        sample_valid <= (afe_cnt == 3'h0);
    end
    i2c_host host (.i_clk(core_clk), .i_dev_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda));
    press_sensor #(.P_MS_CYCLES(10)) dut (
        .i_core_clk(core_clk), .i_rst_b(rst_b), .i_afe_clk(afe_clk),
        .i_sample_valid(sample_valid), .i_pressure_sample(p_smp), .i_temp_sample(t_smp),
        .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
        .o_ready_o(ready_o), .o_ready_oe(ready_oe)
    );
    function automatic logic [7:0] mode_byte(input logic [2:0] a, input logic en,
                                             input logic [1:0] m);
        return {a, en, 2'b10, m};
    endfunction : mode_byte
    task automatic summarize();
        if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        host.start();
        host.put(8'hBA, ack);
        `CHECK(ack, 1'b1)
        host.put(idx, ack);
        host.put(d, ack);
        `CHECK(ack, 1'b1)
        `CHECK(sda_o, 1'h0)
        host.stop();
    endtask : wr
    task automatic rd(input logic [7:0] idx, input int n);
        host.start();
        host.put(8'hBA, ack);
        host.put(idx, ack);
        host.start();
        host.put(8'hBB, ack);
        `CHECK(ack, 1'b1)
        for (int i = 0; i < n; i++) host.get(i == n - 1, rb[i]);
        host.stop();
    endtask : rd
    task automatic results(input logic [21:0] p, input logic [15:0] t, input logic [7:0] st,
                           input logic chk_st);
        rd(press_pkg::IDX_STATUS, 6);
        if (chk_st) `CHECK(rb[0], st)
        `CHECK(({rb[1], rb[2], rb[3]}), ({p, 2'h0}))
        `CHECK(({rb[4], rb[5]}), t)
    endtask : results
    task automatic wait_ready(input int lim);
        int n = 0;
        while (ready_oe !== 1'b1 && n < lim) begin
            @(negedge core_clk);
            n++;
        end
        `CHECK(ready_oe, 1'b1)
        `CHECK(ready_o, 1'h0)
    endtask : wait_ready
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 80000) begin
            num_errors++;
            summarize();
        end
    end
    initial begin
        void'($urandom(20));
        repeat (20) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (5) @(negedge core_clk);
        host.start();
        host.put(8'hB8, ack);
        `CHECK(ack, 1'b0)
        host.stop();
        rd(press_pkg::IDX_MODE, 1);
        `CHECK(rb[0], 8'h00)
        wr(press_pkg::IDX_POWER, 8'h01);
        wr(press_pkg::IDX_RELEASE, 8'h01);
        rd(8'h20, 1);
        `CHECK(rb[0], 8'h00)
        rd(press_pkg::IDX_MODE, 1);
        `CHECK(rb[0], press_pkg::MODE_RST)
        results(22'h0, 16'h0, 8'h00, 1'b1);
        for (int a = 0; a < 7; a++) begin
            p_smp = 22'($urandom);
            t_smp = 16'($urandom);
            wr(press_pkg::IDX_MODE, mode_byte(3'(a), a[0], press_pkg::MODE_SINGLE));
            if (a[0]) wait_ready(press_pkg::TM_MS[a] * 10 + 100);
            else begin
                repeat (press_pkg::TM_MS[a] * 10 + 100) @(negedge core_clk);
                `CHECK(ready_oe, 1'b0)
            end
            results(p_smp, t_smp, 8'h01, 1'b1);
            `CHECK(ready_oe, 1'b0)
            rd(press_pkg::IDX_MODE, 1);
            `CHECK(rb[0], mode_byte(3'(a), a[0], press_pkg::MODE_STANDBY))
        end
        p_smp = 22'($urandom);
        t_smp = 16'($urandom);
        wr(press_pkg::IDX_MODE, mode_byte(3'h0, 1'b1, press_pkg::MODE_REPEAT));
        wait_ready(700);
        results(p_smp, t_smp, 8'h01, 1'b0);
        p_smp = 22'($urandom);
        t_smp = 16'($urandom);
        repeat (1300) @(negedge core_clk);
        results(p_smp, t_smp, 8'h01, 1'b0);
        wr(press_pkg::IDX_MODE, 8'h00);
        rd(press_pkg::IDX_STATUS, 1);
        repeat (1300) @(negedge core_clk);
        rd(press_pkg::IDX_STATUS, 1);
        `CHECK(rb[0], 8'h00)
        p_old = p_smp;
        t_old = t_smp;
        p_smp = 22'($urandom);
        wr(press_pkg::IDX_MODE, mode_byte(3'h6, 1'b1, press_pkg::MODE_SINGLE));
        wr(press_pkg::IDX_MODE, 8'h00);
        repeat (2600) @(negedge core_clk);
        results(p_old, t_old, 8'h00, 1'b1);
        `CHECK(ready_oe, 1'b0)
        foreach (bad[i]) begin
            wr(press_pkg::IDX_MODE, bad[i]);
            repeat (700) @(negedge core_clk);
            rd(press_pkg::IDX_MODE, 1);
            `CHECK(rb[0], {bad[i][7:2], 2'b00})
            rd(press_pkg::IDX_STATUS, 1);
            `CHECK(rb[0], 8'h00)
        end
        wr(press_pkg::IDX_MODE, 8'h10);
        wr(press_pkg::IDX_RELEASE, 8'h00);
        rd(press_pkg::IDX_MODE, 1);
        `CHECK(rb[0], 8'h00)
        wr(press_pkg::IDX_RELEASE, 8'h01);
        rd(press_pkg::IDX_MODE, 1);
        `CHECK(rb[0], press_pkg::MODE_RST)
        results(22'h0, 16'h0, 8'h00, 1'b1);
        summarize();
    end
endmodule : tb
